// File: rtl/rfs_consts.svh
// Named constants of the switch driver serial control port.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef RFS_CONSTS_SVH
`define RFS_CONSTS_SVH

// ****************************************************************
// Frame and register layout
// ****************************************************************
`define RFS_FRAME_BITS 16
`define RFS_FRAME_MSB 15
`define RFS_REG_BITS 8
`define RFS_CTL_WR_EN 7
`define RFS_CTL_FAULT 6
`define RFS_CTL_SLEEP 5
`define RFS_CTL_FLT_DIS 4
`define RFS_CTL_HV_UV_OFF 3
`define RFS_CTL_PUMP 1
`define RFS_THROW_ONE 0
`define RFS_THROW_TWO 1
`define RFS_THROW_THREE 2
`define RFS_THROW_FOUR 3
`define RFS_STATE_RESET 8'h00
`define RFS_CTL_RESET 8'h00

// ****************************************************************
// Synchronised pin slots and their idle levels
// ****************************************************************
`define RFS_PIN_COUNT 8
`define RFS_PIN_SCK 0
`define RFS_PIN_MOSI 1
`define RFS_PIN_SEL 2
`define RFS_PIN_MODE 3
`define RFS_PIN_VDD_UV 4
`define RFS_PIN_VPP_UV 5
`define RFS_PIN_PUMP 6
`define RFS_PIN_FLT 7
`define RFS_PIN_IDLE 8'h04

// ****************************************************************
// Clock rates
// ****************************************************************
`define RFS_REF_CLK_HZ 10000000
`define RFS_SCK_MAX_HZ 33000000
`define RFS_SCK_MIN_CYCLES ((`RFS_REF_CLK_HZ + `RFS_SCK_MAX_HZ - 1) / `RFS_SCK_MAX_HZ)

`endif

// File: rtl/rfs_fault_guard.sv
// Fault shutdown latch of the switch driver.
// Assumes synchronous inputs on ref_clk.
`timescale 1ns/1ns

module rfs_fault_guard (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Fault condition and policy.
    input wire logic fault_now,
    input wire logic shutdown_enable,
    input wire logic pump_request,
    // Shutdown in force.
    output logic tripped
);

    // ****************************************************************
    // Shutdown latch
    // ****************************************************************
    // A fault with shutdown enabled trips the latch; only a low pump request releases it,
    // so the pump must be dropped and raised again to restart.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            tripped <= 1'b0;
        end
        else if (fault_now && shutdown_enable)
        begin
            tripped <= 1'b1;
        end
        else if (!pump_request)
        begin
            tripped <= 1'b0;
        end
    end

endmodule

// File: rtl/rfs_pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes every pin_raw bit is asynchronous to ref_clk.
`timescale 1ns/1ns
`include "rfs_consts.svh"

module rfs_pin_sync #(
    parameter int WIDTH = `RFS_PIN_COUNT,
    parameter logic [WIDTH-1:0] IDLE_LEVEL = `RFS_PIN_IDLE
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Raw pins.
    input wire logic [WIDTH-1:0] pin_raw,
    // Filtered levels and one-cycle edge pulses.
    output logic [WIDTH-1:0] pin_level,
    output logic [WIDTH-1:0] pin_rise,
    output logic [WIDTH-1:0] pin_fall
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // ****************************************************************
    // Per-pin chain
    // ****************************************************************
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_pin
        // A change is accepted once the second and third stages agree.
        always_ff @(posedge ref_clk or posedge reset)
        begin
            if (reset)
            begin
                stage1[i] <= IDLE_LEVEL[i];
                stage2[i] <= IDLE_LEVEL[i];
                stage3[i] <= IDLE_LEVEL[i];
                pin_level[i] <= IDLE_LEVEL[i];
                pin_rise[i] <= 1'b0;
                pin_fall[i] <= 1'b0;
            end
            else
            begin
                stage1[i] <= pin_raw[i];
                stage2[i] <= stage1[i];
                stage3[i] <= stage2[i];
                if (stage2[i] == stage3[i])
                begin
                    pin_level[i] <= stage2[i];
                end
                pin_rise[i] <= (stage2[i] == stage3[i]) && stage2[i] && !pin_level[i];
                pin_fall[i] <= (stage2[i] == stage3[i]) && !stage2[i] && pin_level[i];
            end
        end
    end

endmodule

// File: rtl/rfs_pkg.sv
// Types shared by the switch driver serial control port.
// Assumes nothing of its surroundings.
package rfs_pkg;

    // Serial port sequencing states.
    typedef enum logic [1:0] {
        RFS_PORT_OFF = 2'b00,
        RFS_PORT_IDLE = 2'b01,
        RFS_PORT_FRAME = 2'b10
    } rfs_port_state_type;

endpackage

// File: rtl/rfs_serial_port.sv
// Top of the serial control port of a four-throw switch driver.
// Assumes all pins are asynchronous to ref_clk and sck runs well below ref_clk / 6.
`timescale 1ns/1ns
`include "rfs_consts.svh"

module rfs_serial_port (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Serial link pins.
    input wire logic sck,
    input wire logic mosi,
    input wire logic select_bar,
    output logic miso,
    // Mode and parallel-mode pins.
    input wire logic mode_select,
    input wire logic pump_enable_pin,
    input wire logic fault_shutdown_pin,
    // Supply comparator levels.
    input wire logic vdd_uv_fault,
    input wire logic vpp_uv_fault,
    // Switch path drives.
    output logic throw_one_enable,
    output logic throw_two_enable,
    output logic throw_three_enable,
    output logic throw_four_enable,
    // Analog control.
    output logic pump_run,
    output logic analog_sleep,
    output logic hv_uv_monitor_off,
    output logic fault_latched_flag
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [`RFS_PIN_COUNT-1:0] pin_raw;
    logic [`RFS_PIN_COUNT-1:0] pin_level;
    logic [`RFS_PIN_COUNT-1:0] pin_rise;
    logic [`RFS_PIN_COUNT-1:0] pin_fall;
    rfs_pkg::rfs_port_state_type port_state;
    rfs_pkg::rfs_port_state_type next_port_state;
    logic [`RFS_FRAME_BITS-1:0] shift_frame;
    logic [`RFS_REG_BITS-1:0] switch_path_state;
    logic [`RFS_REG_BITS-1:0] driver_control_status;
    logic [`RFS_REG_BITS-1:0] ctrl_view;
    logic [`RFS_FRAME_BITS-1:0] reg_word;
    logic serial_mode;
    logic load_now;
    logic commit_now;
    logic commit_we;
    logic sck_rise;
    logic sck_fall;
    logic sel_rise;
    logic sel_fall;
    logic mosi_level;
    logic monitor_off;
    logic fault_now;
    logic shutdown_enable;
    logic pump_request;
    logic sleep_request;
    logic tripped;
    logic shift_msb;
    logic frame_msb;
    logic [`RFS_REG_BITS-1:0] shift_low;

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    // Gather every asynchronous input into one synchroniser bank.
    assign pin_raw[`RFS_PIN_SCK] = sck;
    assign pin_raw[`RFS_PIN_MOSI] = mosi;
    assign pin_raw[`RFS_PIN_SEL] = select_bar;
    assign pin_raw[`RFS_PIN_MODE] = mode_select;
    assign pin_raw[`RFS_PIN_VDD_UV] = vdd_uv_fault;
    assign pin_raw[`RFS_PIN_VPP_UV] = vpp_uv_fault;
    assign pin_raw[`RFS_PIN_PUMP] = pump_enable_pin;
    assign pin_raw[`RFS_PIN_FLT] = fault_shutdown_pin;

    rfs_pin_sync #(
        .WIDTH(`RFS_PIN_COUNT),
        .IDLE_LEVEL(`RFS_PIN_IDLE)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_raw(pin_raw),
        .pin_level(pin_level),
        .pin_rise(pin_rise),
        .pin_fall(pin_fall)
    );

    // Name the filtered events used by the port.
    assign serial_mode = !pin_level[`RFS_PIN_MODE];
    assign sck_rise = pin_rise[`RFS_PIN_SCK]; // Sampled edges, so sck must stay well below ref_clk.
    assign sck_fall = pin_fall[`RFS_PIN_SCK];
    assign sel_rise = pin_rise[`RFS_PIN_SEL];
    assign sel_fall = pin_fall[`RFS_PIN_SEL];
    assign mosi_level = pin_level[`RFS_PIN_MOSI];

    // ****************************************************************
    // Port sequencing
    // ****************************************************************
    // Select low opens a frame, select high closes it; parallel mode parks the port.
    always_comb
    begin
        next_port_state = port_state;
        case (port_state)
            rfs_pkg::RFS_PORT_OFF:
            begin
                if (serial_mode && pin_level[`RFS_PIN_SEL])
                begin
                    next_port_state = rfs_pkg::RFS_PORT_IDLE;
                end
            end
            rfs_pkg::RFS_PORT_IDLE:
            begin
                if (!serial_mode)
                begin
                    next_port_state = rfs_pkg::RFS_PORT_OFF;
                end
                else if (sel_fall)
                begin
                    next_port_state = rfs_pkg::RFS_PORT_FRAME;
                end
            end
            rfs_pkg::RFS_PORT_FRAME:
            begin
                if (!serial_mode)
                begin
                    next_port_state = rfs_pkg::RFS_PORT_OFF;
                end
                else if (sel_rise)
                begin
                    next_port_state = rfs_pkg::RFS_PORT_IDLE;
                end
            end
            default:
            begin
                next_port_state = rfs_pkg::RFS_PORT_OFF;
            end
        endcase
    end

    // State register of the port sequencer.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            port_state <= rfs_pkg::RFS_PORT_OFF;
        end
        else
        begin
            port_state <= next_port_state;
        end
    end

    // Frame open and frame close strobes.
    assign load_now = (port_state == rfs_pkg::RFS_PORT_IDLE) && serial_mode && sel_fall;
    assign commit_now = (port_state == rfs_pkg::RFS_PORT_FRAME) && serial_mode && sel_rise;
    assign commit_we = commit_now && shift_frame[`RFS_FRAME_MSB];

    // ****************************************************************
    // Shift path
    // ****************************************************************
    // Register image returned to the host, control byte first.
    assign ctrl_view = {driver_control_status[`RFS_REG_BITS-1:`RFS_CTL_SLEEP+1],
        driver_control_status[`RFS_CTL_SLEEP] && serial_mode,
        driver_control_status[`RFS_CTL_SLEEP-1:0]};
    assign reg_word = {ctrl_view, switch_path_state};

    // Load the registers at frame open, then shift MOSI in on each SCK rise.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            shift_frame <= {`RFS_FRAME_BITS{1'b0}};
        end
        else if (load_now)
        begin
            shift_frame <= reg_word;
        end
        else if ((port_state == rfs_pkg::RFS_PORT_FRAME) && sck_rise)
        begin
            shift_frame <= {shift_frame[`RFS_FRAME_MSB-1:0], mosi_level};
        end
    end

    // MISO shows the MSB at frame open and the next bit on each SCK fall.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            miso <= 1'b0;
        end
        else if (!serial_mode)
        begin
            miso <= 1'b0;
        end
        else if (load_now)
        begin
            miso <= reg_word[`RFS_FRAME_MSB];
        end
        else if ((port_state == rfs_pkg::RFS_PORT_FRAME) && sck_fall)
        begin
            miso <= shift_frame[`RFS_FRAME_MSB];
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Switch state: written only by a frame with write-enable set.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            switch_path_state <= `RFS_STATE_RESET;
        end
        else if (commit_we)
        begin
            switch_path_state <= shift_frame[`RFS_REG_BITS-1:0];
        end
    end

    // Control: a present fault sets its bit and wins over a write of zero.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            driver_control_status <= `RFS_CTL_RESET;
        end
        else
        begin
            if (commit_we)
            begin
                driver_control_status <= shift_frame[`RFS_FRAME_MSB:`RFS_REG_BITS];
            end
            if (fault_now)
            begin
                driver_control_status[`RFS_CTL_FAULT] <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Fault and analog control
    // ****************************************************************
    // Serial mode takes its settings from the register, not the pins.
    assign monitor_off = serial_mode ? driver_control_status[`RFS_CTL_HV_UV_OFF]
        : !pin_level[`RFS_PIN_PUMP];
    assign shutdown_enable = serial_mode ? !driver_control_status[`RFS_CTL_FLT_DIS]
        : !pin_level[`RFS_PIN_FLT];
    assign pump_request = serial_mode ? driver_control_status[`RFS_CTL_PUMP]
        : pin_level[`RFS_PIN_PUMP];
    assign sleep_request = ctrl_view[`RFS_CTL_SLEEP];
    assign fault_now = pin_level[`RFS_PIN_VDD_UV] || (pin_level[`RFS_PIN_VPP_UV] && !monitor_off);

    rfs_fault_guard u_fault_guard (
        .ref_clk(ref_clk),
        .reset(reset),
        .fault_now(fault_now),
        .shutdown_enable(shutdown_enable),
        .pump_request(pump_request),
        .tripped(tripped)
    );

    // Output drives; throws and pump cut off while a fault shutdown is in force.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            throw_one_enable <= 1'b0;
            throw_two_enable <= 1'b0;
            throw_three_enable <= 1'b0;
            throw_four_enable <= 1'b0;
            pump_run <= 1'b0;
            analog_sleep <= 1'b0;
            hv_uv_monitor_off <= 1'b0;
            fault_latched_flag <= 1'b0;
        end
        else
        begin
            throw_one_enable <= switch_path_state[`RFS_THROW_ONE] && !tripped;
            throw_two_enable <= switch_path_state[`RFS_THROW_TWO] && !tripped;
            throw_three_enable <= switch_path_state[`RFS_THROW_THREE] && !tripped;
            throw_four_enable <= switch_path_state[`RFS_THROW_FOUR] && !tripped;
            pump_run <= pump_request && !tripped && !sleep_request;
            analog_sleep <= sleep_request;
            hv_uv_monitor_off <= monitor_off;
            fault_latched_flag <= driver_control_status[`RFS_CTL_FAULT];
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    // Helper views for the checks below.
    assign shift_msb = shift_frame[`RFS_FRAME_MSB];
    assign frame_msb = reg_word[`RFS_FRAME_MSB];
    assign shift_low = shift_frame[`RFS_REG_BITS-1:0];

    // Parallel mode parks the port.
    a_parallel_parks:
    assert property (@(posedge ref_clk) disable iff (reset)
        !serial_mode |=> (port_state == rfs_pkg::RFS_PORT_OFF))
    else $error("Port not parked in parallel mode.");

    // Frame open puts the register MSB on MISO.
    a_miso_first_bit:
    assert property (@(posedge ref_clk) disable iff (reset)
        load_now |=> (miso == $past(frame_msb)))
    else $error("MISO does not show the MSB at frame open.");

    // Each SCK rise shifts the MOSI level into the low bit.
    a_mosi_sampled:
    assert property (@(posedge ref_clk) disable iff (reset)
        (port_state == rfs_pkg::RFS_PORT_FRAME) && sck_rise && !sel_rise
        |=> (shift_frame[0] == $past(mosi_level)))
    else $error("MOSI not sampled on SCK rise.");

    // Each SCK fall presents the current MSB on MISO.
    a_miso_next_bit:
    assert property (@(posedge ref_clk) disable iff (reset)
        (port_state == rfs_pkg::RFS_PORT_FRAME) && sck_fall && serial_mode
        |=> (miso == $past(shift_msb)))
    else $error("MISO not advanced on SCK fall.");

    // Frame open loads the previous register content for return.
    a_previous_data:
    assert property (@(posedge ref_clk) disable iff (reset)
        load_now |=> (shift_frame == $past(reg_word)))
    else $error("Shift path not loaded with register content.");

    // A write frame lands in the state register one cycle after close.
    a_write_commit:
    assert property (@(posedge ref_clk) disable iff (reset)
        commit_now && shift_msb |=> (switch_path_state == $past(shift_low)))
    else $error("Write frame not committed.");

    // A read-only frame leaves both registers untouched.
    a_read_only_hold:
    assert property (@(posedge ref_clk) disable iff (reset)
        commit_now && !shift_msb && !fault_now
        |=> $stable(switch_path_state) && $stable(driver_control_status))
    else $error("Read-only frame changed a register.");

    // A present fault is latched the next cycle and reported two cycles later.
    a_fault_latched:
    assert property (@(posedge ref_clk) disable iff (reset)
        fault_now |=> driver_control_status[`RFS_CTL_FAULT] ##1 fault_latched_flag)
    else $error("Supply fault not latched.");

    // Sleep stays low while in parallel mode.
    a_sleep_forced:
    assert property (@(posedge ref_clk) disable iff (reset)
        !serial_mode ##1 !serial_mode |-> !analog_sleep)
    else $error("Sleep active in parallel mode.");

    // A fault shutdown drops every throw and the pump.
    a_shutdown_drops:
    assert property (@(posedge ref_clk) disable iff (reset)
        tripped |=> !pump_run && !throw_one_enable && !throw_two_enable
            && !throw_three_enable && !throw_four_enable)
    else $error("Outputs live during fault shutdown.");

endmodule

// File: tb/rfs_host_model.sv
// Host side of the serial link: one controller clocking frames into the port.
// Assumes the caller waits for each transfer to finish before starting the next.
`timescale 1ns/1ns

module rfs_host_model (
    // Serial link pins.
    output logic sck,
    output logic mosi,
    output logic select_bar,
    input wire logic miso
);
    // Link idles with select high, clock low and data pulled down.
    initial
    begin
        sck = 1'b0;
        mosi = 1'b0;
        select_bar = 1'b1;
    end

    // Shifts n bits out MSB first at 800 ns per bit and gathers the returned bits.
    // Data is read late in the high phase, since the port answers some cycles after each fall.
    task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx = 32'h0;
        #413 select_bar = 1'b0;
        #800;
        for (int i = n - 1; i >= 0; i--)
        begin
            mosi = tx[i];
            #400 sck = 1'b1;
            #399 rx = {rx[30:0], miso};
            #1 sck = 1'b0;
        end
        mosi = 1'b0;
        #400 select_bar = 1'b1;
        #800;
    endtask
endmodule

// File: tb/rfs_serial_port_tb.sv
// Self-checking testbench of the switch driver serial control port.
// Assumes the rtl files and the host model are compiled first.
`timescale 1ns/1ns

module rfs_serial_port_tb;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic mode_select = 1'b0;
    logic pump_pin = 1'b0;
    logic flt_pin = 1'b0;
    logic vdd_uv = 1'b0;
    logic vpp_uv = 1'b0;
    logic sck, mosi, select_bar, miso;
    logic t1, t2, t3, t4, pump_run, analog_sleep, hv_off, fault_flag;
    logic [31:0] outs;
    logic [31:0] rx;
    logic [31:0] r;
    logic [15:0] prev;
    logic [15:0] b;
    int fail_count = 0;
    int cmp_count = 0;

    // Reference clock of 100 ns.
    always #50 ref_clk = ~ref_clk;

    // Outputs gathered for comparison.
    assign outs = {24'h0, t4, t3, t2, t1, pump_run, analog_sleep, hv_off, fault_flag};

    rfs_serial_port dut (.ref_clk(ref_clk), .reset(reset), .sck(sck), .mosi(mosi), .select_bar(select_bar),
        .miso(miso), .mode_select(mode_select), .pump_enable_pin(pump_pin), .fault_shutdown_pin(flt_pin),
        .vdd_uv_fault(vdd_uv), .vpp_uv_fault(vpp_uv), .throw_one_enable(t1), .throw_two_enable(t2),
        .throw_three_enable(t3), .throw_four_enable(t4), .pump_run(pump_run), .analog_sleep(analog_sleep),
        .hv_uv_monitor_off(hv_off), .fault_latched_flag(fault_flag));

    rfs_host_model host (.sck(sck), .mosi(mosi), .select_bar(select_bar), .miso(miso));

    // ****************************************************************
    // Checking helpers
    // ****************************************************************
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Expected output pins for a control byte, a state byte and a shutdown in force.
    function logic [31:0] exp_out(input logic [7:0] cv, input logic [7:0] sv, input logic trip);
        return {24'h0, sv[3:0] & {4{~trip}}, cv[1] & ~cv[5] & ~trip, cv[5], cv[3], cv[6]};
    endfunction

    // Writes one frame, checks the returned word and then the output pins.
    task write_frame(input logic [7:0] cv, input logic [7:0] sv);
        host.xfer(16, {16'h0, cv, sv}, rx);
        check(rx, {16'h0, prev});
        prev = {cv, sv};
        repeat (12) @(posedge ref_clk);
        check(outs, exp_out(cv, sv, 1'b0));
    endtask

    task summarize;
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Cuts a hung run short.
    initial
    begin
        #4000000;
        fail_count++;
        summarize();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        prev = 16'h0;
        r = $urandom(77948);
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk) reset = 1'b0;
        repeat (3) @(posedge ref_clk);
        check(outs, 32'h0);
        host.xfer(16, 32'h0, rx);
        check(rx, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 10; i++)
        begin
            r = $urandom;
            @(negedge ref_clk);
            pump_pin = r[16];
            flt_pin = r[17];
            write_frame({2'b10, r[5:0]}, {4'h0, r[11:8]});
        end
        write_frame(8'hbf, 8'h0f);
        write_frame(8'h80, 8'h00);
        $display("test random writes done");
        host.xfer(16, {17'h0, r[14:0]}, rx);
        check(rx, {16'h0, prev});
        repeat (12) @(posedge ref_clk);
        check(outs, exp_out(prev[15:8], prev[7:0], 1'b0));
        $display("test read only done");
        r = $urandom;
        b = {2'b10, r[5:0], 4'h0, r[11:8]};
        host.xfer(32, {16'h8205, b}, rx);
        check(rx, {prev, 16'h8205});
        prev = b;
        repeat (12) @(posedge ref_clk);
        check(outs, exp_out(b[15:8], b[7:0], 1'b0));
        $display("test daisy chain done");
        write_frame(8'h82, 8'h0f);
        @(negedge ref_clk) vpp_uv = 1'b1;
        repeat (10) @(negedge ref_clk);
        vpp_uv = 1'b0;
        repeat (12) @(posedge ref_clk);
        check(outs, exp_out(8'hc2, 8'h0f, 1'b1));
        prev = 16'hc20f;
        write_frame(8'h80, 8'h0f);
        write_frame(8'h82, 8'h0f);
        write_frame(8'h9a, 8'h0f);
        @(negedge ref_clk) vpp_uv = 1'b1;
        repeat (10) @(negedge ref_clk);
        vpp_uv = 1'b0;
        vdd_uv = 1'b1;
        repeat (10) @(negedge ref_clk);
        vdd_uv = 1'b0;
        repeat (12) @(posedge ref_clk);
        check(outs, exp_out(8'hda, 8'h0f, 1'b0));
        prev = 16'hda0f;
        write_frame(8'ha0, 8'h00);
        $display("test fault done");
        @(negedge ref_clk) mode_select = 1'b1;
        pump_pin = 1'b1;
        repeat (12) @(posedge ref_clk);
        check({31'h0, analog_sleep}, 32'h0);
        check(outs, 32'h8);
        @(negedge ref_clk) flt_pin = 1'b0;
        vpp_uv = 1'b1;
        repeat (10) @(negedge ref_clk);
        vpp_uv = 1'b0;
        repeat (12) @(posedge ref_clk);
        check(outs, 32'h1);
        @(negedge ref_clk) mode_select = 1'b0;
        repeat (12) @(posedge ref_clk);
        check({31'h0, analog_sleep}, 32'h1);
        $display("test parallel mode done");
        @(negedge ref_clk) reset = 1'b1;
        repeat (2) @(negedge ref_clk);
        reset = 1'b0;
        repeat (3) @(posedge ref_clk);
        check(outs, 32'h0);
        host.xfer(16, 32'h0, rx);
        check(rx, 32'h0);
        $display("test mid-run reset done");
        summarize();
    end
endmodule
